// file: design/reset_interrupt_bus_control.v
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "reset_interrupt_bus_control_defines.vh"

// How it works
// - reset low three cycles forces address high
// - leave reset: latch mode, init, mask, vector
// - enable clock is oscillator divided by four
// - nmi falling edge served despite mask
// - nmi: core stacks, vector from fffc
// - external requests level sensitive, masked, boundary
// - maskable entry sets mask, fetches vector
// - external requests gated by control bits 0,1
// - internal sources merge into one request
// - fixed priority order selects vector address
// - expanded mode: direction low on writes
// - expanded mode: active-low read, write strobes
// - opcode fetch indicator low on opcodes
// - memory ready low stretches enable high
// - ready ignored internal/invalid, honoured in halt
// - memory ready gated by control bit 2
// - halt after instruction: bus available, float
// - interrupts during halt served after release
// - halt during sleep keeps sleep, releases bus
// - wait instruction alone keeps bus available low
// - halt gated by bit 3, off single-chip
// - disabled external pin gives no wake
module reset_interrupt_bus_control (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  // pins
  input  wire        reset_pin_n_i,
  input  wire        mode_select_0_i,
  input  wire        mode_select_1_i,
  input  wire        nmi_n_i,
  input  wire        external_request_one_n_i,
  input  wire        external_request_two_n_i,
  input  wire        memory_ready_in_i,
  input  wire        halt_n_i,
  output wire        e_clk_o,
  output reg  [15:0] addr_o,
  output wire        addr_oe_o,
  output reg  [7:0]  data_o,
  output wire        data_oe_o,
  output reg         read_n_o,
  output reg         write_n_o,
  output reg         rw_o,
  output wire        strobe_oe_o,
  output reg         opcode_fetch_n_o,
  output reg         bus_available_o,
  // core side
  output wire        sys_en_o,
  output wire        core_hold_o,
  output reg         init_regs_o,
  output reg         vector_fetch_o,
  output reg  [15:0] vector_addr_o,
  output reg         interrupt_start_o,
  output reg         interrupt_mask_o,
  output wire        wake_o,
  output wire        internal_merged_request_o,
  output reg  [1:0]  mode_o,
  input  wire        instr_done_i,
  input  wire        mask_clear_i,
  input  wire        trap_i,
  input  wire        software_interrupt_i,
  input  wire        sleep_i,
  input  wire        wait_for_interrupt_instr_i,
  input  wire        cpu_access_i,
  input  wire        cpu_write_i,
  input  wire        cpu_internal_i,
  input  wire        cpu_invalid_i,
  input  wire        cpu_opfetch_i,
  input  wire [15:0] cpu_addr_i,
  input  wire [7:0]  cpu_wdata_i,
  input  wire        capture_interrupt_i,
  input  wire        compare_interrupt_i,
  input  wire        overflow_interrupt_i,
  input  wire        counter_match_interrupt_i,
  input  wire        receive_full_flag_i,
  input  wire        overrun_framing_flag_i,
  input  wire        transmit_empty_flag_i,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // --------
  // sequencer states
  // --------
  localparam [5:0] ST_RESET  = 6'b000001;
  localparam [5:0] ST_LATCH  = 6'b000010;
  localparam [5:0] ST_INIT   = 6'b000100;
  localparam [5:0] ST_VECTOR = 6'b001000;
  localparam [5:0] ST_RUN    = 6'b010000;
  localparam [5:0] ST_HALT   = 6'b100000;

  // --------
  // pin synchronisers
  // --------
  localparam NSYNC = 8;
  wire [NSYNC-1:0] pins_raw = {halt_n_i, memory_ready_in_i, external_request_two_n_i,
                               external_request_one_n_i, nmi_n_i, mode_select_1_i,
                               mode_select_0_i, reset_pin_n_i};
  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge mclk_i) begin
        if (!rst_n_i) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pins_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  wire reset_pin_s = sync2_q[0];
  wire mode0_s     = sync2_q[1];
  wire mode1_s     = sync2_q[2];
  wire nmi_s       = sync2_q[3];
  wire ext_one_s   = ~sync2_q[4];
  wire ext_two_s   = ~sync2_q[5];
  wire mem_ready_s = sync2_q[6];
  wire halt_s      = ~sync2_q[7];

  // --------
  // registers
  // --------
  reg  [5:0] state_q;
  reg  [3:0] ctrl_q;
  reg  [1:0] phase_q;
  reg        stretch_q;
  reg  [1:0] low_cnt_q;
  reg        nmi_prev_q;
  reg        nmi_pend_q;
  reg        aw_held_q;
  reg        w_held_q;
  reg  [7:0] aw_addr_q;
  reg  [7:0] w_data_q;

  wire expanded = (mode_o == `MODE_EXP_1) || (mode_o == `MODE_EXP_2);
  wire halted   = (state_q == ST_HALT);
  wire running  = (state_q == ST_RUN);
  wire halt_req = halt_s & ctrl_q[`BIT_HALT_EN] & expanded;

  // --------
  // enable clock divider and stretching
  // --------
  wire ext_cycle = cpu_access_i & ~cpu_internal_i & ~cpu_invalid_i;
  wire mr_stall  = ~mem_ready_s & ctrl_q[`BIT_MEM_READY_EN] & expanded
                   & (ext_cycle | halted);
  wire phase_end = (phase_q == `SYS_DIV_PHASE_LAST);
  wire sys_en    = phase_end & ~mr_stall;
  assign sys_en_o = sys_en;
  assign e_clk_o  = phase_q[1] | stretch_q;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      phase_q   <= 2'b00;
      stretch_q <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'b01;
      if (phase_end)
        stretch_q <= mr_stall;
    end
  end

  // --------
  // reset pin, mode latch and startup sequence
  // --------
  wire reset_hold = (state_q == ST_RESET) && (low_cnt_q == `RESET_MIN_CYC);
  assign core_hold_o = ~running;

  // --------
  // interrupt requests and priority
  // --------
  wire ext_one_req = ext_one_s & ctrl_q[`BIT_EXT_ONE_EN];
  wire ext_two_req = ext_two_s & ctrl_q[`BIT_EXT_TWO_EN];
  wire serial_req  = receive_full_flag_i | overrun_framing_flag_i | transmit_empty_flag_i;
  assign internal_merged_request_o = capture_interrupt_i | compare_interrupt_i
                                   | overflow_interrupt_i | counter_match_interrupt_i
                                   | serial_req;
  wire maskable_any = ext_one_req | ext_two_req | internal_merged_request_o;
  assign wake_o = nmi_pend_q | (maskable_any & ~interrupt_mask_o);
  wire nmi_edge = nmi_prev_q & ~nmi_s;

  reg        take_any;
  reg        take_mask;
  reg [15:0] take_vec;
  always @* begin
    take_any  = 1'b1;
    take_mask = 1'b0;
    take_vec  = `VEC_TRAP;
    if (trap_i)
      take_vec = `VEC_TRAP;
    else if (nmi_pend_q)
      take_vec = `VEC_NMI;
    else if (software_interrupt_i)
      take_vec = `VEC_SOFT;
    else if (interrupt_mask_o)
      take_any = 1'b0;
    else begin
      take_mask = 1'b1;
      if (ext_one_req)
        take_vec = `VEC_EXT_ONE;
      else if (capture_interrupt_i)
        take_vec = `VEC_CAPTURE;
      else if (compare_interrupt_i)
        take_vec = `VEC_COMPARE;
      else if (overflow_interrupt_i)
        take_vec = `VEC_OVERFLOW;
      else if (counter_match_interrupt_i)
        take_vec = `VEC_COUNTER_MATCH;
      else if (ext_two_req)
        take_vec = `VEC_EXT_TWO;
      else if (serial_req)
        take_vec = `VEC_SERIAL;
      else begin
        take_any  = 1'b0;
        take_mask = 1'b0;
      end
    end
  end

  // boundary for service: instruction end, or while sleeping/waiting
  wire boundary = sys_en & (instr_done_i | sleep_i | wait_for_interrupt_instr_i);
  wire serve    = running & boundary & ~halt_req & take_any;

  // --------
  // main sequencer
  // --------
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q           <= ST_RESET;
      low_cnt_q         <= 2'd0;
      mode_o            <= `MODE_SINGLE;
      init_regs_o       <= 1'b0;
      vector_fetch_o    <= 1'b0;
      vector_addr_o     <= `VEC_RESET;
      interrupt_start_o <= 1'b0;
      interrupt_mask_o  <= 1'b1;
      nmi_prev_q        <= 1'b1;
      nmi_pend_q        <= 1'b0;
      bus_available_o   <= 1'b0;
    end else begin
      init_regs_o       <= 1'b0;
      vector_fetch_o    <= 1'b0;
      interrupt_start_o <= 1'b0;
      nmi_prev_q        <= nmi_s;
      if (nmi_edge)
        nmi_pend_q <= 1'b1;
      else if (serve && !trap_i && nmi_pend_q)
        nmi_pend_q <= 1'b0;
      if (mask_clear_i)
        interrupt_mask_o <= 1'b0;
      if (!reset_pin_s) begin
        state_q <= ST_RESET;
        if (sys_en && low_cnt_q != `RESET_MIN_CYC)
          low_cnt_q <= low_cnt_q + 2'd1;
      end else begin
        case (state_q)
          ST_RESET: begin
            low_cnt_q <= 2'd0;
            state_q   <= ST_LATCH;
          end
          ST_LATCH: begin
            // after rst_n_i the mode synchronisers still hold their reset level here; after a reset pin release they hold the pins
            state_q <= ST_INIT;
          end
          ST_INIT: begin
            mode_o           <= {mode1_s, mode0_s};
            init_regs_o      <= 1'b1;
            interrupt_mask_o <= 1'b1;
            state_q          <= ST_VECTOR;
          end
          ST_VECTOR: begin
            vector_addr_o  <= `VEC_RESET;
            vector_fetch_o <= 1'b1;
            state_q        <= ST_RUN;
          end
          ST_RUN: begin
            if (boundary && halt_req) begin
              state_q         <= ST_HALT;
              bus_available_o <= 1'b1;
            end else if (serve) begin
              vector_addr_o     <= take_vec;
              vector_fetch_o    <= 1'b1;
              interrupt_start_o <= 1'b1;
              interrupt_mask_o  <= 1'b1;
            end
          end
          ST_HALT: begin
            if (!halt_req) begin
              state_q         <= ST_RUN;
              bus_available_o <= 1'b0;
            end
          end
          default: state_q <= ST_RESET;
        endcase
      end
    end
  end

  // --------
  // expanded-mode bus outputs
  // --------
  wire drive_bus = expanded & ~halted;
  assign addr_oe_o   = drive_bus | reset_hold;
  assign strobe_oe_o = drive_bus;
  assign data_oe_o   = drive_bus & ext_cycle & cpu_write_i & running;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      addr_o           <= `ADDR_ALL_HIGH;
      data_o           <= 8'h00;
      read_n_o         <= 1'b1;
      write_n_o        <= 1'b1;
      rw_o             <= 1'b1;
      opcode_fetch_n_o <= 1'b1;
    end else begin
      addr_o           <= reset_hold ? `ADDR_ALL_HIGH : cpu_addr_i;
      data_o           <= cpu_wdata_i;
      read_n_o         <= ~(running & ext_cycle & ~cpu_write_i);
      write_n_o        <= ~(running & ext_cycle & cpu_write_i);
      rw_o             <= ~(running & ext_cycle & cpu_write_i);
      opcode_fetch_n_o <= ~(running & cpu_access_i & cpu_opfetch_i);
    end
  end

  // --------
  // axi4-lite register slave
  // --------
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire       aw_fire = s_axi_awvalid & s_axi_awready;
  wire       w_fire  = s_axi_wvalid & s_axi_wready;
  wire       aw_now  = aw_held_q | aw_fire;
  wire       w_now   = w_held_q | w_fire;
  wire [7:0] wa      = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [7:0] wd      = w_held_q ? w_data_q : s_axi_wdata[7:0];
  wire       wlane   = w_held_q ? 1'b1 : s_axi_wstrb[0];
  reg        wlane_q;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_q       <= `CTRL_RESET;
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 8'h00;
      wlane_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (init_regs_o)
        ctrl_q <= `CTRL_RESET;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (aw_now && w_now && !s_axi_bvalid) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa == `ADDR_RAM_PORT5_CTRL) begin
          s_axi_bresp <= `RESP_OKAY;
          if (w_held_q ? wlane_q : wlane)
            ctrl_q <= wd[3:0];
        end else if (wa == `ADDR_STATUS || wa == `ADDR_INT_SOURCES)
          s_axi_bresp <= `RESP_OKAY;
        else
          s_axi_bresp <= `RESP_DECERR;
      end else begin
        if (aw_fire) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata[7:0];
          wlane_q  <= s_axi_wstrb[0];
        end
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_RAM_PORT5_CTRL: s_axi_rdata <= {28'h000_0000, ctrl_q};
          `ADDR_STATUS:         s_axi_rdata <= {24'h00_0000, state_q[5], state_q[4],
                                                nmi_pend_q, interrupt_mask_o,
                                                bus_available_o, halted, mode_o};
          `ADDR_INT_SOURCES:    s_axi_rdata <= {24'h00_0000, transmit_empty_flag_i,
                                                overrun_framing_flag_i, receive_full_flag_i,
                                                counter_match_interrupt_i,
                                                overflow_interrupt_i, compare_interrupt_i,
                                                ext_two_req, ext_one_req};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_DECERR;
          end
        endcase
      end
    end
  end

endmodule // reset_interrupt_bus_control
`default_nettype wire

// file: design/reset_interrupt_bus_control_defines.vh
`ifndef RESET_INTERRUPT_BUS_CONTROL_DEFINES_VH
`define RESET_INTERRUPT_BUS_CONTROL_DEFINES_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_RAM_PORT5_CTRL   8'h14
`define ADDR_STATUS           8'h20
`define ADDR_INT_SOURCES      8'h24

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define BIT_EXT_ONE_EN        0
`define BIT_EXT_TWO_EN        1
`define BIT_MEM_READY_EN      2
`define BIT_HALT_EN           3
`define CTRL_RESET            4'b1100

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define RESP_OKAY             2'b00
`define RESP_DECERR           2'b11

// ----------------------------------------------------------------
// timing: system clock is osc/4, reset pin low at least 3 cycles
// ----------------------------------------------------------------
`define SYS_DIV_PHASE_LAST    2'b11
`define RESET_MIN_CYC         2'd3

// ----------------------------------------------------------------
// mode pin codes {mode_select_1, mode_select_0}
// ----------------------------------------------------------------
`define MODE_EXP_1            2'b01
`define MODE_EXP_2            2'b10
`define MODE_SINGLE           2'b11

// ----------------------------------------------------------------
// vector high-byte addresses and the all-high reset address
// ----------------------------------------------------------------
`define VEC_RESET             16'hFFFE
`define VEC_TRAP              16'hFFEE
`define VEC_NMI               16'hFFFC
`define VEC_SOFT              16'hFFFA
`define VEC_EXT_ONE           16'hFFF8
`define VEC_CAPTURE           16'hFFF6
`define VEC_COMPARE           16'hFFF4
`define VEC_OVERFLOW          16'hFFF2
`define VEC_COUNTER_MATCH     16'hFFEC
`define VEC_EXT_TWO           16'hFFEA
`define VEC_SERIAL            16'hFFF0
`define ADDR_ALL_HIGH         16'hFFFF

`endif

// file: tb/reset_interrupt_bus_control_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "reset_interrupt_bus_control_defines.vh"
module rib_props (
  input wire logic        mclk_i, rst_n_i, reset_pin_n_i, halt_n_i, e_clk_o, addr_oe_o,
  input wire logic        data_oe_o, read_n_o, write_n_o, rw_o, strobe_oe_o, bus_available_o,
  input wire logic        sys_en_o, core_hold_o, init_regs_o, vector_fetch_o,
  input wire logic        interrupt_start_o, interrupt_mask_o, internal_merged_request_o,
  input wire logic        capture_interrupt_i, compare_interrupt_i, overflow_interrupt_i,
  input wire logic        counter_match_interrupt_i, receive_full_flag_i,
  input wire logic        overrun_framing_flag_i, transmit_empty_flag_i,
  input wire logic [15:0] addr_o, vector_addr_o,
  input wire logic [1:0]  mode_o
);
  logic [4:0] low_q;
  // mclk cycles with the reset pin low, saturating
  always @(posedge mclk_i) begin
    if (!rst_n_i || reset_pin_n_i) low_q <= 5'h00;
    else if (low_q != 5'h1F) low_q <= low_q + 5'h01;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_eclk_quarter: assert property (sys_en_o |=> !e_clk_o [*2] ##1 e_clk_o)
    else $error("enable clock shape wrong");
  a_reset_addr: assert property (low_q >= 5'h14 |-> addr_o == `ADDR_ALL_HIGH && addr_oe_o)
    else $error("address not forced high in reset");
  a_boot_vector: assert property (init_regs_o |-> ##[1:12]
    (vector_fetch_o && vector_addr_o == `VEC_RESET && interrupt_mask_o))
    else $error("boot vector fetch missing");
  a_entry_mask: assert property (interrupt_start_o |-> interrupt_mask_o && vector_fetch_o)
    else $error("entry without mask or fetch");
  a_mask_refuse: assert property (interrupt_start_o && $past(interrupt_mask_o) |->
    vector_addr_o inside {`VEC_TRAP, `VEC_NMI, `VEC_SOFT}) else $error("masked entry taken");
  a_halt_defers: assert property (interrupt_start_o |-> !bus_available_o)
    else $error("entry while halted");
  a_write_dir: assert property (!write_n_o |-> !rw_o && read_n_o && strobe_oe_o)
    else $error("write strobe without write direction");
  a_single_quiet: assert property (mode_o == `MODE_SINGLE |-> !strobe_oe_o && !bus_available_o)
    else $error("single chip drives strobes or halts");
  a_ba_float: assert property (bus_available_o |-> !(addr_oe_o || data_oe_o || strobe_oe_o))
    else $error("bus driven while released");
  a_halt_free: assert property (halt_n_i [*6] |-> !bus_available_o)
    else $error("bus available without halt");
  a_mode_held: assert property (!core_hold_o && !$past(core_hold_o) |-> $stable(mode_o))
    else $error("mode changed while running");
  a_merge_or: assert property (internal_merged_request_o == (capture_interrupt_i ||
    compare_interrupt_i || overflow_interrupt_i || counter_match_interrupt_i ||
    receive_full_flag_i || overrun_framing_flag_i || transmit_empty_flag_i))
    else $error("merged request mismatch");
  c_entry: cover property (interrupt_start_o);
  c_halted: cover property ($rose(bus_available_o));
  c_write: cover property (!write_n_o);
  c_stretch: cover property (e_clk_o [*3]);
endmodule // rib_props
bind reset_interrupt_bus_control rib_props u_props (.*);
`default_nettype wire

// file: tb/ext_bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ext_bus_partner (
  input  wire logic       mclk_i,
  input  wire logic       stall_i,
  input  wire logic       halt_req_i,
  input  wire logic [3:0] waits_i,
  output logic            mem_ready_o,
  output logic            halt_n_o
);
  logic [5:0] cnt_q;
  always @(posedge mclk_i) cnt_q <= stall_i ? cnt_q + 6'h01 : 6'h00;
  // slow memory: ready low for whole system cycles
  assign mem_ready_o = !(stall_i && cnt_q < {waits_i, 2'b00});
  assign halt_n_o    = !halt_req_i;
endmodule // ext_bus_partner
`default_nettype wire

// file: tb/reset_interrupt_bus_control_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "reset_interrupt_bus_control_defines.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
`define WT(c) begin k = 0; while (!(c) && k < 400) begin @(posedge mclk_i); k++; end \
  `CHK("wait", 1'b1, k < 400) end
module reset_interrupt_bus_control_test;
  logic mclk_i = '0, rst_n_i = '0, reset_pin_n_i = '1, mode_select_0_i = '1, mode_select_1_i = '0;
  logic nmi_n_i = '1, external_request_one_n_i = '1, external_request_two_n_i = '1;
  logic instr_done_i = '0, mask_clear_i = '0, trap_i = '0, software_interrupt_i = '0;
  logic sleep_i = '0, wait_for_interrupt_instr_i = '0, cpu_access_i = '0, cpu_write_i = '0;
  logic cpu_internal_i = '0, cpu_invalid_i = '0, cpu_opfetch_i = '0, capture_interrupt_i = '0;
  logic compare_interrupt_i = '0, overflow_interrupt_i = '0, counter_match_interrupt_i = '0;
  logic receive_full_flag_i = '0, overrun_framing_flag_i = '0, transmit_empty_flag_i = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, stall = '0, halt_req = '0;
  logic [15:0] cpu_addr_i = '0;
  logic [7:0]  cpu_wdata_i = '0, s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hF, waits = 4'h2;
  wire memory_ready_in_i, halt_n_i, e_clk_o, addr_oe_o, data_oe_o, read_n_o, write_n_o, rw_o;
  wire strobe_oe_o, opcode_fetch_n_o, bus_available_o, sys_en_o, core_hold_o, init_regs_o;
  wire vector_fetch_o, interrupt_start_o, interrupt_mask_o, wake_o, internal_merged_request_o;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [15:0] addr_o, vector_addr_o;
  wire [7:0]  data_o;
  wire [1:0]  mode_o, s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int fails = 0, n_checks = 0, k, n;
  // source set {trap, soft, ext1, cap, cmp, ovf, match, ext2, rx, err, tx} and vector
  logic [26:0] rows [18] = '{27'h400_FFEE, 27'h600_FFEE, 27'h200_FFFA, 27'h300_FFFA,
    27'h100_FFF8, 27'h180_FFF8, 27'h080_FFF6, 27'h0C0_FFF6, 27'h040_FFF4, 27'h020_FFF2,
    27'h030_FFF2, 27'h010_FFEC, 27'h018_FFEC, 27'h008_FFEA, 27'h00C_FFEA, 27'h004_FFF0,
    27'h002_FFF0, 27'h001_FFF0};

  reset_interrupt_bus_control u_dut (.*);
  ext_bus_partner u_far (.mclk_i, .stall_i(stall), .halt_req_i(halt_req), .waits_i(waits),
    .mem_ready_o(memory_ready_in_i), .halt_n_o(halt_n_i));

  always #50 mclk_i = ~mclk_i;

  task give_verdict();
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task boot(input logic [1:0] m);
    @(posedge mclk_i); rst_n_i <= '0; {mode_select_1_i, mode_select_0_i} <= m;
    repeat (10) @(posedge mclk_i); rst_n_i <= '1;
    `WT(vector_fetch_o)
    `CHK("boot_vec", `VEC_RESET, vector_addr_o)
    `CHK("boot_mask", 1'b1, interrupt_mask_o)
    `CHK("mode", m, mode_o)
  endtask
  task src(input logic [10:0] s);
    instr_done_i <= '0;
    external_request_one_n_i <= !s[8]; external_request_two_n_i <= !s[3];
    repeat (3) @(posedge mclk_i);
    {trap_i, software_interrupt_i} <= s[10:9];
    {capture_interrupt_i, compare_interrupt_i, overflow_interrupt_i} <= s[7:5];
    counter_match_interrupt_i <= s[4];
    {receive_full_flag_i, overrun_framing_flag_i, transmit_empty_flag_i} <= s[2:0];
    instr_done_i <= '1;
  endtask
  task clr();
    repeat (4) @(posedge mclk_i); mask_clear_i <= '1;
    repeat (4) @(posedge mclk_i); mask_clear_i <= '0;
  endtask
  task serve(input logic [15:0] v);
    `WT(interrupt_start_o)
    `CHK("vector", v, vector_addr_o)
    `CHK("mask_set", 1'b1, interrupt_mask_o)
  endtask
  task quiet(input int c);
    k = 0;
    repeat (c) begin @(posedge mclk_i); if (interrupt_start_o) k++; end
    `CHK("no_entry", 0, k)
  endtask
  // length of one stretched-or-plain high phase of the enable clock
  task meas();
    while (!e_clk_o) @(posedge mclk_i);
    while (e_clk_o) @(posedge mclk_i);
    stall <= '1;
    while (!e_clk_o) @(posedge mclk_i);
    n = 0;
    while (e_clk_o && n < 60) begin @(posedge mclk_i); n++; end
    stall <= '0;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, b;
    @(posedge mclk_i); s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= '1; s_axi_wvalid <= '1; s_axi_bready <= '1;
    do begin
      @(negedge mclk_i); aw = s_axi_awready; w = s_axi_wready; b = s_axi_bvalid;
      if (b) `CHK("bresp", r, s_axi_bresp)
      @(posedge mclk_i);
      if (aw) s_axi_awvalid <= '0;
      if (w) s_axi_wvalid <= '0;
      if (b) s_axi_bready <= '0;
    end while (!b);
  endtask
  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar, b;
    @(posedge mclk_i); s_axi_araddr <= a; s_axi_arvalid <= '1; s_axi_rready <= '1;
    do begin
      @(negedge mclk_i); ar = s_axi_arready; b = s_axi_rvalid;
      if (b) begin `CHK("rdata", d, s_axi_rdata) `CHK("rresp", r, s_axi_rresp) end
      @(posedge mclk_i);
      if (ar) s_axi_arvalid <= '0;
      if (b) s_axi_rready <= '0;
    end while (!b);
  endtask

  initial begin
    repeat (60000) @(posedge mclk_i);
    fails++;
    give_verdict();
  end

  initial begin
    boot(2'b01);
    instr_done_i <= '1;
    axr(`ADDR_RAM_PORT5_CTRL, 32'h0000_000C, `RESP_OKAY);
    axr(8'h40, 32'h0000_0000, `RESP_DECERR);
    axw(8'h40, 32'h0000_000F, `RESP_DECERR);
    axw(`ADDR_RAM_PORT5_CTRL, 32'h0000_000F, `RESP_OKAY);
    axr(`ADDR_RAM_PORT5_CTRL, 32'h0000_000F, `RESP_OKAY);
    foreach (rows[i]) begin
      clr(); src(rows[i][26:16]); serve(rows[i][15:0]); src(11'h000);
    end
    external_request_one_n_i <= '0; quiet(40);
    nmi_n_i <= '0; serve(`VEC_NMI);
    nmi_n_i <= '1; clr(); serve(`VEC_EXT_ONE);
    external_request_one_n_i <= '1;
    axw(`ADDR_RAM_PORT5_CTRL, 32'h0000_000C, `RESP_OKAY);
    external_request_two_n_i <= '0; clr(); quiet(40);
    `CHK("wake", 1'b0, wake_o)
    external_request_two_n_i <= '1;
    axw(`ADDR_RAM_PORT5_CTRL, 32'h0000_000F, `RESP_OKAY);
    cpu_access_i <= '1; cpu_write_i <= '1; cpu_addr_i <= 16'h8123; cpu_wdata_i <= 8'hA5;
    `WT(!write_n_o) `CHK("rw_wr", 1'b0, rw_o)
    `CHK("wdata", 8'hA5, data_o) `CHK("waddr", 16'h8123, addr_o)
    cpu_write_i <= '0; cpu_opfetch_i <= '1;
    `WT(!read_n_o) `CHK("rw_rd", 1'b1, rw_o)
    `WT(!opcode_fetch_n_o)
    cpu_opfetch_i <= '0;
    meas(); `CHK("stretch", 1'b1, n > 2 && n % 4 == 2)
    cpu_internal_i <= '1; meas(); `CHK("internal", 2, n)
    cpu_internal_i <= '0;
    axw(`ADDR_RAM_PORT5_CTRL, 32'h0000_000B, `RESP_OKAY);
    meas(); `CHK("ready_off", 2, n)
    axw(`ADDR_RAM_PORT5_CTRL, 32'h0000_000F, `RESP_OKAY);
    halt_req <= '1; `WT(bus_available_o)
    `CHK("float", 3'b000, {addr_oe_o, data_oe_o, strobe_oe_o})
    external_request_one_n_i <= '0; clr(); quiet(40);
    meas(); `CHK("halt_stretch", 1'b1, n > 2 && n % 4 == 2)
    halt_req <= '0; serve(`VEC_EXT_ONE);
    external_request_one_n_i <= '1; cpu_access_i <= '0;
    for (int j = 0; j < 2; j++) begin
      instr_done_i <= '0; {sleep_i, wait_for_interrupt_instr_i} <= j ? 2'b10 : 2'b01;
      repeat (20) @(posedge mclk_i); `CHK("ba_idle", 1'b0, bus_available_o)
      halt_req <= '1; `WT(bus_available_o)
      halt_req <= '0; `WT(!bus_available_o)
    end
    {sleep_i, wait_for_interrupt_instr_i} <= 2'b00; instr_done_i <= '1;
    reset_pin_n_i <= '0; repeat (24) @(posedge mclk_i);
    `CHK("addr_high", 16'hFFFF, addr_o) `CHK("addr_oe", 1'b1, addr_oe_o)
    reset_pin_n_i <= '1; `WT(vector_fetch_o)
    `CHK("pin_vec", `VEC_RESET, vector_addr_o)
    boot(2'b11);
    halt_req <= '1; repeat (20) @(posedge mclk_i);
    `CHK("single_ba", 1'b0, bus_available_o)
    halt_req <= '0; {mode_select_1_i, mode_select_0_i} <= 2'b01;
    repeat (20) @(posedge mclk_i); `CHK("mode_kept", 2'b11, mode_o)
    give_verdict();
  end
endmodule // reset_interrupt_bus_control_test
`default_nettype wire
